// *** src/fcc_pkg.sv ***
package fcc_pkg;
    // Register port addresses
    localparam logic [7:0] SFR_CMD = 8'hb9;
    localparam logic [7:0] SFR_KEY = 8'hba;
    localparam logic [7:0] SFR_DATA = 8'hbc;
    localparam logic [7:0] SFR_ADDR_LOW = 8'hc6;
    localparam logic [7:0] SFR_ADDR_HIGH = 8'hc7;

    // Reset values
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] KEY_RESET = 8'hff;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] ADDR_RESET = 8'h00;

    localparam logic [7:0] KEY_UNLOCK = 8'h3b;

    // Command codes
    localparam logic [7:0] CMD_WRITE_BYTE = 8'h01;
    localparam logic [7:0] CMD_ERASE_PAGE = 8'h02;
    localparam logic [7:0] CMD_ERASE_ALL = 8'h03;
    localparam logic [7:0] CMD_READ_BYTE = 8'h04;
    localparam logic [7:0] CMD_PROTECT = 8'h08;

    // Array geometry and protection area
    localparam int PAGE_LSB = 9;
    localparam logic [6:0] PAGE_COUNT = 7'h7c;
    localparam logic [7:0] PROT_HIGH = 8'hf7;
    localparam logic [7:0] PROT_KEY_LOW = 8'heb;
    localparam logic [7:0] RP_LOW = 8'hec;
    localparam logic [7:0] WP_LOW = 8'hf0;
    localparam logic [4:0] RP_BYTES = 5'h04;
    localparam logic [4:0] PROT_LOAD_LAST = 5'h13;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_READ = 3'h1,
        OP_PROG = 3'h2,
        OP_ERASE_PAGE = 3'h3,
        OP_ERASE_ALL = 3'h4
    } fcc_op_e;

    typedef enum logic [1:0] {
        ST_LOAD_REQ = 2'b00,
        ST_LOAD_WAIT = 2'b01,
        ST_IDLE = 2'b11,
        ST_BUSY = 2'b10
    } fcc_state_e;

    typedef struct packed {
        fcc_op_e op;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fcc_flash_req_s;
endpackage : fcc_pkg

// *** src/fcc_flash_command_controller.sv ***
// Behaviour
// RULE_01: A command is accepted only while the unlock key register holds 0x3b.
// RULE_02: A command write without the unlock key leaves the array and data register untouched.
// RULE_03: Each completed operation returns the unlock key register to its locked value 0xff.
// RULE_04: The core's program counter is stalled from the command write until the operation ends.
// RULE_05: Interrupts are held pending while an operation runs and released when it ends.
// RULE_06: Only the core is stalled; timers and other peripherals keep running.
// RULE_07: Code 1 programs the data register byte at the high/low address.
// RULE_08: Code 2 erases the whole 512-byte page holding the high/low address.
// RULE_09: Code 3 erases all of the array; application code should not issue it.
// RULE_10: Code 4 reads the byte at the high/low address into the data register.
// RULE_11: Codes 5 to 7 and any other undefined code start no operation.
// RULE_12: Code 8 programs one protection byte in the area at the top of the array.
// RULE_13: The protect command uses only the low address and the data register.
// RULE_14: Each of the 124 pages has a write/erase protect bit, cleared meaning protected.
// RULE_15: Read protection covers groups of four pages with one bit per group.
`timescale 1ns/1ns
`default_nettype none
module fcc_flash_command_controller (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_we,
    input wire logic sfr_re,
    output logic [7:0] sfr_rdata,
    output fcc_pkg::fcc_flash_req_s flash_req,
    input wire logic [7:0] flash_rdata,
    input wire logic flash_done,
    output logic core_stall,
    output logic irq_defer
);
    fcc_pkg::fcc_state_e state;
    fcc_pkg::fcc_state_e next_state;
    logic [7:0] flash_command;
    logic [7:0] next_flash_command;
    logic [7:0] flash_unlock_key;
    logic [7:0] next_flash_unlock_key;
    logic [7:0] flash_data;
    logic [7:0] next_flash_data;
    logic [7:0] flash_addr_low;
    logic [7:0] next_flash_addr_low;
    logic [7:0] flash_addr_high;
    logic [7:0] next_flash_addr_high;
    logic [127:0] wp_bits;
    logic [127:0] next_wp_bits;
    logic [31:0] rp_bits;
    logic [31:0] next_rp_bits;
    logic [4:0] load_idx;
    logic [4:0] next_load_idx;
    fcc_pkg::fcc_flash_req_s next_flash_req;
    logic [7:0] next_sfr_rdata;
    logic next_core_stall;
    logic next_irq_defer;
    logic [15:0] cur_addr;

    function automatic logic [6:0] page_of(input logic [15:0] addr);
        page_of = addr[15:fcc_pkg::PAGE_LSB];
    endfunction : page_of

    // Byte program and page erase need an existing page whose write/erase bit is still set
    function automatic logic wr_ok(input logic [15:0] addr, input logic [127:0] wp);
        logic [6:0] pg;
        pg = page_of(addr);
        wr_ok = (pg < fcc_pkg::PAGE_COUNT) && wp[pg]; // see RULE_14
    endfunction : wr_ok

    assign cur_addr = {flash_addr_high, flash_addr_low};

    always_comb begin
        logic [6:0] pg;
        logic [7:0] byte_sel;
        pg = page_of(cur_addr);
        byte_sel = 8'h00;
        next_state = state;
        next_flash_command = flash_command;
        next_flash_unlock_key = flash_unlock_key;
        next_flash_data = flash_data;
        next_flash_addr_low = flash_addr_low;
        next_flash_addr_high = flash_addr_high;
        next_wp_bits = wp_bits;
        next_rp_bits = rp_bits;
        next_load_idx = load_idx;
        next_flash_req = flash_req;
        next_flash_req.op = fcc_pkg::OP_NONE;
        next_core_stall = core_stall;
        next_sfr_rdata = sfr_rdata;

        if (sfr_re) begin
            if (sfr_addr == fcc_pkg::SFR_CMD) begin
                next_sfr_rdata = flash_command;
            end else if (sfr_addr == fcc_pkg::SFR_KEY) begin
                next_sfr_rdata = flash_unlock_key;
            end else if (sfr_addr == fcc_pkg::SFR_DATA) begin
                next_sfr_rdata = flash_data;
            end else if (sfr_addr == fcc_pkg::SFR_ADDR_LOW) begin
                next_sfr_rdata = flash_addr_low;
            end else if (sfr_addr == fcc_pkg::SFR_ADDR_HIGH) begin
                next_sfr_rdata = flash_addr_high;
            end else begin
                next_sfr_rdata = 8'h00;
            end
        end

        case (state)
            // Protection bytes are copied into shadow bits before the core may run
            fcc_pkg::ST_LOAD_REQ: begin
                next_flash_req.op = fcc_pkg::OP_READ;
                next_flash_req.addr = {fcc_pkg::PROT_HIGH, fcc_pkg::RP_LOW + {3'h0, load_idx}};
                next_state = fcc_pkg::ST_LOAD_WAIT;
            end
            fcc_pkg::ST_LOAD_WAIT: begin
                if (flash_done) begin
                    if (load_idx < fcc_pkg::RP_BYTES) begin
                        next_rp_bits[{load_idx[1:0], 3'h0} +: 8] = flash_rdata; // see RULE_15
                    end else begin
                        next_wp_bits[{load_idx[3:0] - 4'h4, 3'h0} +: 8] = flash_rdata;
                    end
                    if (load_idx == fcc_pkg::PROT_LOAD_LAST) begin
                        next_state = fcc_pkg::ST_IDLE;
                        next_core_stall = 1'b0;
                    end else begin
                        next_load_idx = load_idx + 5'h01;
                        next_state = fcc_pkg::ST_LOAD_REQ;
                    end
                end
            end
            // Core is stalled in the busy state, so it cannot write registers then
            fcc_pkg::ST_IDLE: begin
                if (sfr_we) begin
                    if (sfr_addr == fcc_pkg::SFR_KEY) begin
                        next_flash_unlock_key = sfr_wdata;
                    end else if (sfr_addr == fcc_pkg::SFR_DATA) begin
                        next_flash_data = sfr_wdata;
                    end else if (sfr_addr == fcc_pkg::SFR_ADDR_LOW) begin
                        next_flash_addr_low = sfr_wdata;
                    end else if (sfr_addr == fcc_pkg::SFR_ADDR_HIGH) begin
                        next_flash_addr_high = sfr_wdata;
                    end else if (sfr_addr == fcc_pkg::SFR_CMD) begin
                        next_flash_command = sfr_wdata;
                        if (flash_unlock_key == fcc_pkg::KEY_UNLOCK) begin // see RULE_01 RULE_02
                            next_flash_req.addr = cur_addr;
                            next_flash_req.wdata = flash_data;
                            next_state = fcc_pkg::ST_BUSY;
                            next_core_stall = 1'b1; // see RULE_04 RULE_06
                            case (sfr_wdata)
                                fcc_pkg::CMD_WRITE_BYTE: begin
                                    // Protection area is not reachable by a plain byte write
                                    if (wr_ok(cur_addr, wp_bits) && !(flash_addr_high
                                            == fcc_pkg::PROT_HIGH && flash_addr_low
                                            >= fcc_pkg::PROT_KEY_LOW)) begin
                                        next_flash_req.op = fcc_pkg::OP_PROG; // see RULE_07
                                    end
                                end
                                fcc_pkg::CMD_ERASE_PAGE: begin
                                    if (wr_ok(cur_addr, wp_bits)) begin
                                        next_flash_req.op = fcc_pkg::OP_ERASE_PAGE; // see RULE_08
                                    end
                                end
                                fcc_pkg::CMD_ERASE_ALL: begin
                                    next_flash_req.op = fcc_pkg::OP_ERASE_ALL; // see RULE_09
                                end
                                fcc_pkg::CMD_READ_BYTE: begin
                                    if (pg < fcc_pkg::PAGE_COUNT && rp_bits[pg[6:2]]) begin
                                        next_flash_req.op = fcc_pkg::OP_READ; // see RULE_10 RULE_15
                                    end
                                end
                                fcc_pkg::CMD_PROTECT: begin
                                    next_flash_req.addr = {fcc_pkg::PROT_HIGH, flash_addr_low}; // see RULE_13
                                    if (flash_addr_low >= fcc_pkg::PROT_KEY_LOW) begin
                                        next_flash_req.op = fcc_pkg::OP_PROG; // see RULE_12
                                    end
                                end
                                default: begin
                                    next_state = fcc_pkg::ST_IDLE; // see RULE_11
                                    next_core_stall = 1'b0;
                                end
                            endcase
                            // A refused protected access still completes and uses up the key
                            if (next_state == fcc_pkg::ST_BUSY
                                    && next_flash_req.op == fcc_pkg::OP_NONE) begin
                                next_state = fcc_pkg::ST_IDLE;
                                next_core_stall = 1'b0;
                                next_flash_unlock_key = fcc_pkg::KEY_RESET; // see RULE_03
                            end
                        end
                    end
                end
            end
            fcc_pkg::ST_BUSY: begin
                if (flash_done) begin
                    if (flash_command == fcc_pkg::CMD_READ_BYTE) begin
                        next_flash_data = flash_rdata; // see RULE_10
                    end else if (flash_command == fcc_pkg::CMD_ERASE_ALL) begin
                        next_wp_bits = '1;
                        next_rp_bits = '1;
                    end else if (flash_command == fcc_pkg::CMD_PROTECT) begin
                        // Programming only clears bits, so the shadow is ANDed
                        if (flash_addr_low >= fcc_pkg::WP_LOW) begin
                            byte_sel = flash_addr_low - fcc_pkg::WP_LOW;
                            next_wp_bits[{byte_sel[3:0], 3'h0} +: 8] =
                                wp_bits[{byte_sel[3:0], 3'h0} +: 8] & flash_data; // see RULE_14
                        end else if (flash_addr_low >= fcc_pkg::RP_LOW) begin
                            byte_sel = flash_addr_low - fcc_pkg::RP_LOW;
                            next_rp_bits[{byte_sel[1:0], 3'h0} +: 8] =
                                rp_bits[{byte_sel[1:0], 3'h0} +: 8] & flash_data; // see RULE_15
                        end
                    end
                    next_flash_unlock_key = fcc_pkg::KEY_RESET; // see RULE_03
                    next_core_stall = 1'b0; // see RULE_04
                    next_state = fcc_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = fcc_pkg::ST_IDLE;
            end
        endcase
        next_irq_defer = next_core_stall; // see RULE_05
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= fcc_pkg::ST_LOAD_REQ;
            flash_command <= fcc_pkg::CMD_RESET;
            flash_unlock_key <= fcc_pkg::KEY_RESET;
            flash_data <= fcc_pkg::DATA_RESET;
            flash_addr_low <= fcc_pkg::ADDR_RESET;
            flash_addr_high <= fcc_pkg::ADDR_RESET;
            wp_bits <= '1;
            rp_bits <= '1;
            load_idx <= 5'h00;
            flash_req <= '0;
            sfr_rdata <= 8'h00;
            core_stall <= 1'b1;
            irq_defer <= 1'b1;
        end else begin
            state <= next_state;
            flash_command <= next_flash_command;
            flash_unlock_key <= next_flash_unlock_key;
            flash_data <= next_flash_data;
            flash_addr_low <= next_flash_addr_low;
            flash_addr_high <= next_flash_addr_high;
            wp_bits <= next_wp_bits;
            rp_bits <= next_rp_bits;
            load_idx <= next_load_idx;
            flash_req <= next_flash_req;
            sfr_rdata <= next_sfr_rdata;
            core_stall <= next_core_stall;
            irq_defer <= next_irq_defer;
        end
    end
endmodule : fcc_flash_command_controller
`default_nettype wire

// *** verif/fcc_flash_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module fcc_flash_model (
    input wire logic mclk,
    input wire fcc_pkg::fcc_flash_req_s flash_req,
    output logic [7:0] flash_rdata,
    output logic flash_done
);
    // Unwritten places read as erased; programming can only clear bits
    logic [7:0] mem [int];
    fcc_pkg::fcc_flash_req_s held;
    int left = 0;
    wire logic fin = left == 1;
    function automatic logic [7:0] peek(input int a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction : peek
    initial {flash_rdata, flash_done} = 9'h000;
    always @(posedge mclk) begin
        flash_done <= 1'b0;
        // Stale data toggles so it is never taken for a fresh answer
        flash_rdata <= ~flash_rdata;
        if (flash_req.op != fcc_pkg::OP_NONE) begin
            held <= flash_req;
            // Erases answer slowly, reads and programs at once
            left <= flash_req.op > fcc_pkg::OP_PROG ? 8 : 1;
        end else if (left > 0) begin
            left <= left - 1;
            flash_done <= fin;
            if (fin && held.op == fcc_pkg::OP_READ) flash_rdata <= peek(held.addr);
            if (fin && held.op == fcc_pkg::OP_PROG) mem[held.addr] = peek(held.addr) & held.wdata;
            if (fin && held.op == fcc_pkg::OP_ERASE_ALL) mem.delete();
            if (fin && held.op == fcc_pkg::OP_ERASE_PAGE) begin
                for (int a = 0; a < 512; a++) mem.delete({held.addr[15:9], 9'h000} + a);
            end
        end
    end
endmodule : fcc_flash_model
`default_nettype wire

// *** verif/fcc_flash_command_controller_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module fcc_flash_command_controller_monitor (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_we,
    input wire logic sfr_re,
    input wire logic [7:0] sfr_rdata,
    input wire fcc_pkg::fcc_flash_req_s flash_req,
    input wire logic [7:0] flash_rdata,
    input wire logic flash_done,
    input wire logic core_stall,
    input wire logic irq_defer
);
    logic [15:0] ptr;
    logic [15:0] next_ptr;
    wire logic is_op = flash_req.op != fcc_pkg::OP_NONE;
    wire logic pw = sfr_we && !core_stall;
    wire logic cw = pw && sfr_addr == fcc_pkg::SFR_CMD;
    // Writes during a stall are dropped by the block, so they are dropped here too
    always_comb begin
        next_ptr = ptr;
        if (pw && sfr_addr == fcc_pkg::SFR_ADDR_HIGH) next_ptr[15:8] = sfr_wdata;
        if (pw && sfr_addr == fcc_pkg::SFR_ADDR_LOW) next_ptr[7:0] = sfr_wdata;
    end
    always_ff @(posedge mclk) ptr <= sys_rst ? 16'h0000 : next_ptr;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    property issues(c, o, a);
        is_op && $past(cw && sfr_wdata == c) |-> flash_req.op == o && flash_req.addr == a;
    endproperty
    op_pulse_a: assert property (is_op |=> !is_op && core_stall)
        else $error("flash request not a single pulse");
    op_cause_a: assert property (is_op && !$past(core_stall) |-> $past(cw))
        else $error("flash request without a command write");
    stall_hold_a: assert property (core_stall && !flash_done |=> core_stall)
        else $error("stall dropped before the operation ended");
    irq_hold_a: assert property (irq_defer == core_stall)
        else $error("interrupt deferral differs from stall");
    bad_code_a: assert property (cw && !(sfr_wdata inside {[8'h01:8'h04], 8'h08})
        |=> (!is_op && !core_stall) [*2]) else $error("undefined code started an operation");
    read_issue_a: assert property (issues(8'h04, fcc_pkg::OP_READ, ptr))
        else $error("read issued at wrong address");
    prog_issue_a: assert property (issues(8'h01, fcc_pkg::OP_PROG, ptr))
        else $error("program issued at wrong address");
    protect_low_a: assert property (issues(8'h08, fcc_pkg::OP_PROG, {8'hf7, ptr[7:0]}))
        else $error("protect byte at wrong address");
    page_issue_a: assert property (issues(8'h02, fcc_pkg::OP_ERASE_PAGE,
        {ptr[15:9], flash_req.addr[8:0]})) else $error("erase issued for wrong page");
    read_cov_c: cover property (is_op && $past(cw && sfr_wdata == 8'h04));
    erase_cov_c: cover property (flash_req.op == fcc_pkg::OP_ERASE_PAGE);
    refuse_cov_c: cover property (cw && sfr_wdata == 8'h01 ##2 !core_stall);
endmodule : fcc_flash_command_controller_monitor
bind fcc_flash_command_controller fcc_flash_command_controller_monitor
    i_fcc_flash_command_controller_monitor (.*);
`default_nettype wire

// *** verif/fcc_flash_command_controller_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module fcc_flash_command_controller_bench;
    logic mclk = 1'b0, sys_rst = 1'b1, sfr_we = 1'b0, sfr_re = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, flash_rdata;
    logic flash_done, core_stall, irq_defer;
    fcc_pkg::fcc_flash_req_s flash_req;
    int n_errors = 0, samples_checked = 0, cycles = 0, n_ops = 0;
    always #20 mclk = ~mclk;
    fcc_flash_command_controller i_fcc_flash_command_controller (.*);
    fcc_flash_model i_fcc_flash_model (.*);
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        n_ops <= n_ops + (flash_req.op != fcc_pkg::OP_NONE);
        if (cycles == 6000) summarize();
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) $display("[FAIL] %0t got %h want %h", $time, s, e);
        n_errors += (s !== e);
    endtask : chk
    // One register access; a read compares the answer with d
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        sfr_addr <= a;
        sfr_wdata <= d;
        {sfr_we, sfr_re} <= {w, !w};
        @(posedge mclk);
        {sfr_we, sfr_re} <= 2'b00;
        @(posedge mclk);
        if (!w) chk(sfr_rdata, d);
    endtask : acc
    task automatic op(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c,
        input logic st);
        acc(1, 8'hc7, a[15:8]);
        acc(1, 8'hc6, a[7:0]);
        acc(1, 8'hbc, d);
        acc(1, 8'hba, 8'h3b);
        acc(1, 8'hb9, c);
        chk({6'h00, core_stall, irq_defer}, {6'h00, st, st});
        for (int i = 0; i < 99 && core_stall !== 1'b0; i++) @(posedge mclk);
    endtask : op
    task automatic t_regs;
        logic [7:0] rsv [5] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'h09};
        acc(0, 8'hba, 8'hff);
        acc(0, 8'h80, 8'h00);
        acc(1, 8'hbc, 8'h55);
        acc(1, 8'hb9, 8'h04);
        acc(0, 8'hbc, 8'h55);
        foreach (rsv[i]) begin
            op(16'h3c00, 8'h00, rsv[i], 1'b0);
            acc(0, 8'hba, 8'h3b);
        end
        chk(n_ops[7:0], 8'h14);
    endtask : t_regs
    task automatic t_rw;
        op(16'h3c00, 8'hf3, 8'h01, 1'b1);
        acc(0, 8'hba, 8'hff);
        op(16'h3c00, 8'h00, 8'h04, 1'b1);
        acc(0, 8'hbc, 8'hf3);
        op(16'h3dff, 8'h12, 8'h01, 1'b1);
        op(16'h3e00, 8'h34, 8'h01, 1'b1);
        op(16'h3d10, 8'h00, 8'h02, 1'b1);
        chk(i_fcc_flash_model.peek(16'h3c00), 8'hff);
        chk(i_fcc_flash_model.peek(16'h3e00), 8'h34);
    endtask : t_rw
    task automatic t_prot;
        op(16'h12f0, 8'hfe, 8'h08, 1'b1);
        chk(i_fcc_flash_model.peek(16'hf7f0), 8'hfe);
        op(16'h0005, 8'h00, 8'h01, 1'b0);
        acc(0, 8'hba, 8'hff);
        op(16'h0800, 8'ha5, 8'h01, 1'b1);
        op(16'h00ec, 8'hfe, 8'h08, 1'b1);
        op(16'h0600, 8'h77, 8'h04, 1'b0);
        acc(0, 8'hbc, 8'h77);
        op(16'h0800, 8'h00, 8'h04, 1'b1);
        acc(0, 8'hbc, 8'ha5);
        op(16'h0000, 8'h00, 8'h03, 1'b1);
        op(16'h0005, 8'h33, 8'h01, 1'b1);
        chk(i_fcc_flash_model.peek(16'h0005), 8'h33);
    endtask : t_prot
    task automatic summarize;
        n_errors += (cycles >= 6000);
        $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 200 && core_stall !== 1'b0; i++) @(posedge mclk);
        t_regs();
        t_rw();
        t_prot();
        summarize();
    end
endmodule : fcc_flash_command_controller_bench
`default_nettype wire
